// ### core/ngp_pkg.sv
// constants, encodings and types shared by the nibble gpio block
package ngp_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NGP_MAX_PORTS = 6;
  localparam int NGP_PORT_W = 4;
  localparam int NGP_MAX_PINS = NGP_MAX_PORTS * NGP_PORT_W;
  localparam int NGP_SEL_W = 3;
  localparam int NGP_KEY_PINS = 16;
  localparam int NGP_DIM_BASE = 16;
  localparam int NGP_DIM_PINS = 8;
  localparam int NGP_RESET_PIN = 16;
  localparam int NGP_CDC_PIN0 = 17;
  localparam int NGP_CDC_PIN1 = 18;
  localparam int NGP_CDC_PINS = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic NGP_DIR_RST = 1'h1;
  localparam logic NGP_DATA_RST = 1'h0;

  // ----------------------------------------------------------------
  // option encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] NGP_PULL_NONE = 2'h0;
  localparam logic [1:0] NGP_PULL_WEAK = 2'h1;
  localparam logic [1:0] NGP_PULL_STRONG = 2'h2;

  localparam logic [1:0] NGP_SINK_NORMAL = 2'h0;
  localparam logic [1:0] NGP_SINK_LARGE = 2'h1;
  localparam logic [1:0] NGP_SINK_CONST = 2'h2;
  localparam logic [1:0] NGP_SINK_DRIVE = 2'h3;

  localparam logic [1:0] NGP_LVL_33 = 2'h0;
  localparam logic [1:0] NGP_LVL_50 = 2'h1;
  localparam logic [1:0] NGP_LVL_83 = 2'h2;
  localparam logic [1:0] NGP_LVL_100 = 2'h3;

  typedef enum logic [1:0] {ROLE_GPIO, ROLE_KEY, ROLE_DIM, ROLE_RESET}
    ngp_role_type;

  typedef enum logic {LD_WAIT, LD_DONE} ngp_load_type;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] level;
  } ngp_sink_type;

endpackage

// ### core/ngp_pin_if.sv
// per-pin signals between the port core and its pad and wake logic
`timescale 1ns/1ps
interface ngp_pin_if
  import ngp_pkg::*;
#(
  parameter int PINS = NGP_MAX_PINS
);
  logic [PINS-1:0] dir;
  logic [PINS-1:0] data;
  logic [PINS-1:0] padIn;
  logic [PINS-1:0] openDrain;
  logic [PINS-1:0] dimLevel;
  ngp_role_type role [PINS];
  logic [1:0] pull [PINS];
  logic [PINS-1:0] padOut;
  logic [PINS-1:0] padOe;
  logic [PINS-1:0] pullWeak;
  logic [PINS-1:0] pullStrong;
  logic [PINS-1:0] readLevel;
  logic [PINS-1:0] mismatch;

  modport core (
    output dir, data, padIn, openDrain, dimLevel, role, pull,
    input padOut, padOe, pullWeak, pullStrong, readLevel, mismatch
  );
  modport mux (
    input dir, data, padIn, openDrain, dimLevel, role, pull,
    output padOut, padOe, pullWeak, pullStrong, readLevel, mismatch
  );
  modport wake (
    input mismatch
  );
endinterface

// ### core/ngp_pad_mux.sv
// per-pin pad drive, pull selection, readback and wake compare
`timescale 1ns/1ps
module ngp_pad_mux
  import ngp_pkg::*;
#(
  parameter int PINS = NGP_MAX_PINS
) (
  // pin bundle
  ngp_pin_if.mux pins
);

  genvar g;
  for (g = 0; g < PINS; g++) begin : pinCell
    logic isGpio;
    logic isOut;
    logic floats;
    assign isGpio = (pins.role[g] == ROLE_GPIO);
    assign isOut = isGpio & ~pins.dir[g];
    // key and reset pads never drive, dim pads always drive
    assign pins.padOut[g] = (pins.role[g] == ROLE_DIM) ?
                            pins.dimLevel[g] : pins.data[g];
    // open drain only pulls low, so its enable follows a zero bit
    assign pins.padOe[g] = (pins.role[g] == ROLE_DIM) |
                           (isOut & (~pins.openDrain[g] | ~pins.data[g]));
    // pulls only act on a pad that listens
    assign floats = (isGpio & pins.dir[g]) | (pins.role[g] == ROLE_RESET);
    assign pins.pullWeak[g] = floats & (pins.pull[g] == NGP_PULL_WEAK);
    assign pins.pullStrong[g] = floats & (pins.pull[g] == NGP_PULL_STRONG);
    assign pins.readLevel[g] = isOut ? pins.data[g] : pins.padIn[g];
    assign pins.mismatch[g] = isGpio & pins.dir[g] &
                              (pins.padIn[g] != pins.data[g]);
  end

endmodule

// ### core/ngp_wake.sv
// halt wake-up request from input pads that disagree with stored data
`timescale 1ns/1ps
module ngp_wake (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstN,
  // core state
  input wire logic halted,
  // pin bundle
  ngp_pin_if.wake pins,
  // request to the core
  output logic wakeReq_q
);

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      wakeReq_q <= 1'h0;
    end else begin
      wakeReq_q <= halted & (|pins.mismatch);
    end
  end

endmodule

// ### core/ngp_top.sv
// nibble gpio ports with direction, data, pin sharing and halt wake-up
`timescale 1ns/1ps
module ngp_top
  import ngp_pkg::*;
#(
  parameter int NUM_PORTS = NGP_MAX_PORTS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // core register access
  input wire logic [NGP_SEL_W-1:0] accPort,
  input wire logic dirWrEn,
  input wire logic dataWrEn,
  input wire logic [NGP_PORT_W-1:0] wrData,
  input wire logic rdEn,
  input wire logic rdDirSel,
  output logic [NGP_PORT_W-1:0] rdData_q,
  output logic rdValid_q,
  // halt handshake
  input wire logic halted,
  output logic wakeReq_q,
  // pads
  input wire logic [NGP_MAX_PINS-1:0] padIn,
  output logic [NGP_MAX_PINS-1:0] padOut,
  output logic [NGP_MAX_PINS-1:0] padOe,
  output logic [NGP_MAX_PINS-1:0] pullWeak,
  output logic [NGP_MAX_PINS-1:0] pullStrong,
  // static options
  input wire logic [NGP_KEY_PINS-1:0] optKeyEn,
  input wire logic [NGP_DIM_PINS-1:0] optDimEn,
  input wire logic optResetEn,
  input wire logic [1:0] optResetPull,
  input wire logic [2*NGP_MAX_PINS-1:0] optPull,
  input wire logic [NGP_MAX_PINS-1:0] optOpenDrain,
  input wire logic [4*NGP_DIM_PINS-1:0] optGpioSink,
  input wire logic [4*NGP_DIM_PINS-1:0] optDimSink,
  input wire logic [NGP_CDC_PINS-1:0] optConstDrive,
  // shared functions
  input wire logic [NGP_DIM_PINS-1:0] dimLevel,
  output logic [NGP_KEY_PINS-1:0] keySense_q,
  output logic extResetReq_q,
  // analog strength selects for ports E and F
  output logic [2*NGP_DIM_PINS-1:0] sinkMode_q,
  output logic [2*NGP_DIM_PINS-1:0] sinkLevel_q,
  output logic [NGP_CDC_PINS-1:0] constDrive_q
);

  if (NUM_PORTS < 1 || NUM_PORTS > NGP_MAX_PORTS) begin : badPorts
    $error("NUM_PORTS must lie between 1 and 6");
  end

  // absent ports see a low pad and never accept writes
  localparam logic [NGP_MAX_PINS:0] PRESENT_W =
    (25'h1 << (NGP_PORT_W * NUM_PORTS)) - 25'h1;
  localparam logic [NGP_MAX_PINS-1:0] PRESENT =
    PRESENT_W[NGP_MAX_PINS-1:0];

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rstMetaN_q;
  logic rstSyncN_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rstMetaN_q <= 1'h0;
      rstSyncN_q <= 1'h0;
    end else begin
      rstMetaN_q <= 1'h1;
      rstSyncN_q <= rstMetaN_q;
    end
  end

  // ----------------------------------------------------------------
  // option capture
  // ----------------------------------------------------------------
  ngp_load_type loadState_q;
  ngp_role_type pinRole_q [NGP_MAX_PINS];
  logic [1:0] pinPull_q [NGP_MAX_PINS];
  logic [NGP_MAX_PINS-1:0] openDrain_q;
  ngp_sink_type gpioSink_q [NGP_DIM_PINS];
  ngp_sink_type dimSink_q [NGP_DIM_PINS];
  logic [NGP_CDC_PINS-1:0] cdcOpt_q;

  // options are strapped once, one edge after release
  always_ff @(posedge ref_clk or negedge rstSyncN_q) begin
    if (!rstSyncN_q) begin
      loadState_q <= LD_WAIT;
    end else if (loadState_q == LD_WAIT) begin
      loadState_q <= LD_DONE;
    end
  end

  always_ff @(posedge ref_clk or negedge rstSyncN_q) begin
    if (!rstSyncN_q) begin
      openDrain_q <= '0;
      cdcOpt_q <= '0;
    end else if (loadState_q == LD_WAIT) begin
      openDrain_q <= optOpenDrain & PRESENT;
      cdcOpt_q <= optConstDrive;
    end
  end

  genvar g;
  for (g = 0; g < NGP_MAX_PINS; g++) begin : pinOpt
    ngp_role_type pick;
    logic [1:0] pullPick;
    if (g == NGP_RESET_PIN) begin : rstPin
      // reset wins over dimming on the shared pin
      assign pick = optResetEn ? ROLE_RESET :
                    optDimEn[g-NGP_DIM_BASE] ? ROLE_DIM : ROLE_GPIO;
      assign pullPick = optResetEn ? optResetPull : optPull[2*g +: 2];
    end else if (g >= NGP_DIM_BASE) begin : dimPin
      assign pick = optDimEn[g-NGP_DIM_BASE] ? ROLE_DIM : ROLE_GPIO;
      assign pullPick = optPull[2*g +: 2];
    end else begin : keyPin
      assign pick = optKeyEn[g] ? ROLE_KEY : ROLE_GPIO;
      assign pullPick = optPull[2*g +: 2];
    end

    always_ff @(posedge ref_clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
        pinRole_q[g] <= ROLE_GPIO;
        pinPull_q[g] <= NGP_PULL_NONE;
      end else if (loadState_q == LD_WAIT) begin
        pinRole_q[g] <= PRESENT[g] ? pick : ROLE_GPIO;
        pinPull_q[g] <= pullPick;
      end
    end
  end

  for (g = 0; g < NGP_DIM_PINS; g++) begin : sinkOpt
    always_ff @(posedge ref_clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
        gpioSink_q[g] <= '{mode: NGP_SINK_NORMAL, level: NGP_LVL_100};
        dimSink_q[g] <= '{mode: NGP_SINK_LARGE, level: NGP_LVL_100};
      end else if (loadState_q == LD_WAIT) begin
        gpioSink_q[g] <= optGpioSink[4*g +: 4];
        dimSink_q[g] <= optDimSink[4*g +: 4];
      end
    end
  end

  // ----------------------------------------------------------------
  // direction and data registers
  // ----------------------------------------------------------------
  logic [NGP_MAX_PINS-1:0] dir_q;
  logic [NGP_MAX_PINS-1:0] data_q;

  always_ff @(posedge ref_clk or negedge rstSyncN_q) begin
    if (!rstSyncN_q) begin
      dir_q <= {NGP_MAX_PINS{NGP_DIR_RST}};
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (dirWrEn && accPort == NGP_SEL_W'(p)) begin
          dir_q[p*NGP_PORT_W +: NGP_PORT_W] <= wrData;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstSyncN_q) begin
    if (!rstSyncN_q) begin
      data_q <= {NGP_MAX_PINS{NGP_DATA_RST}};
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (dataWrEn && accPort == NGP_SEL_W'(p)) begin
          data_q[p*NGP_PORT_W +: NGP_PORT_W] <= wrData;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pad logic and wake-up
  // ----------------------------------------------------------------
  ngp_pin_if #(.PINS(NGP_MAX_PINS)) pinIf ();

  assign pinIf.dir = dir_q;
  assign pinIf.data = data_q;
  assign pinIf.padIn = padIn & PRESENT;
  assign pinIf.openDrain = openDrain_q;
  assign pinIf.dimLevel = {dimLevel, {NGP_DIM_BASE{1'b0}}};
  for (g = 0; g < NGP_MAX_PINS; g++) begin : pinWire
    assign pinIf.role[g] = pinRole_q[g];
    assign pinIf.pull[g] = pinPull_q[g];
  end

  ngp_pad_mux #(.PINS(NGP_MAX_PINS)) padMux (
    .pins(pinIf.mux)
  );

  // relies on software syncing data bits before halt
  ngp_wake wakeLogic (
    .ref_clk(ref_clk),
    .rstN(rstSyncN_q),
    .halted(halted),
    .pins(pinIf.wake),
    .wakeReq_q(wakeReq_q)
  );

  assign padOut = pinIf.padOut;
  assign padOe = pinIf.padOe;
  assign pullWeak = pinIf.pullWeak;
  assign pullStrong = pinIf.pullStrong;

  // ----------------------------------------------------------------
  // readback, one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstSyncN_q) begin
    if (!rstSyncN_q) begin
      rdData_q <= '0;
      rdValid_q <= 1'h0;
    end else begin
      rdValid_q <= rdEn;
      if (rdEn) begin
        rdData_q <= '0;
        for (int p = 0; p < NUM_PORTS; p++) begin
          if (accPort == NGP_SEL_W'(p)) begin
            // readLevel picks pad or stored bit
            rdData_q <= rdDirSel ? dir_q[p*NGP_PORT_W +: NGP_PORT_W] :
                        pinIf.readLevel[p*NGP_PORT_W +: NGP_PORT_W];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // shared function outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstSyncN_q) begin
    if (!rstSyncN_q) begin
      keySense_q <= '0;
    end else begin
      for (int i = 0; i < NGP_KEY_PINS; i++) begin
        keySense_q[i] <= (pinRole_q[i] == ROLE_KEY) & pinIf.padIn[i];
      end
    end
  end

  // reset pad is level sampled; filtering belongs to the reset block
  always_ff @(posedge ref_clk or negedge rstSyncN_q) begin
    if (!rstSyncN_q) begin
      extResetReq_q <= 1'h0;
    end else begin
      extResetReq_q <= (pinRole_q[NGP_RESET_PIN] == ROLE_RESET) &
                       pinIf.padIn[NGP_RESET_PIN];
    end
  end

  // constant-sink dimming assumes matching gpio option
  always_ff @(posedge ref_clk or negedge rstSyncN_q) begin
    if (!rstSyncN_q) begin
      sinkMode_q <= '0;
      sinkLevel_q <= '0;
    end else begin
      for (int k = 0; k < NGP_DIM_PINS; k++) begin
        if (pinRole_q[NGP_DIM_BASE+k] == ROLE_DIM) begin
          sinkMode_q[2*k +: 2] <= dimSink_q[k].mode;
          sinkLevel_q[2*k +: 2] <= dimSink_q[k].level;
        end else begin
          sinkMode_q[2*k +: 2] <= gpioSink_q[k].mode;
          sinkLevel_q[2*k +: 2] <= gpioSink_q[k].level;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstSyncN_q) begin
    if (!rstSyncN_q) begin
      constDrive_q <= '0;
    end else begin
      constDrive_q[0] <= cdcOpt_q[0] &
        (pinRole_q[NGP_CDC_PIN0] inside {ROLE_GPIO, ROLE_DIM});
      constDrive_q[1] <= cdcOpt_q[1] &
        (pinRole_q[NGP_CDC_PIN1] inside {ROLE_GPIO, ROLE_DIM});
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstSyncN_q);

  dir_write_a: assert property (dirWrEn && accPort == 3'h0 |=>
    dir_q[3:0] == $past(wrData)) else $error("direction write lost");
  out_enable_a: assert property (pinRole_q[0] == ROLE_GPIO &&
    !dir_q[0] && !openDrain_q[0] |-> padOe[0])
    else $error("output pin not driven");
  read_pad_a: assert property (rdEn && !rdDirSel &&
    accPort == 3'h0 && dir_q[1] && pinRole_q[1] == ROLE_GPIO |=>
    rdValid_q && rdData_q[1] == $past(padIn[1]))
    else $error("input read not pad level");
  read_store_a: assert property (rdEn && !rdDirSel &&
    accPort == 3'h0 && !dir_q[1] && pinRole_q[1] == ROLE_GPIO |=>
    rdData_q[1] == $past(data_q[1])) else $error("output read wrong");
  drive_data_a: assert property (pinRole_q[2] == ROLE_GPIO &&
    !dir_q[2] && padOe[2] |-> padOut[2] == data_q[2])
    else $error("pad not driven with data");
  wake_req_a: assert property (halted && pinRole_q[0] == ROLE_GPIO &&
    dir_q[0] && padIn[0] != data_q[0] |=> wakeReq_q)
    else $error("missed wake-up");
  wake_quiet_a: assert property (!halted |=> !wakeReq_q)
    else $error("wake-up while running");
  key_dir_a: assert property (pinRole_q[3] == ROLE_KEY |->
    !padOe[3] ##1 keySense_q[3] == $past(padIn[3]))
    else $error("key pin misbehaves");
  dim_drive_a: assert property (pinRole_q[17] == ROLE_DIM |->
    padOe[17] && padOut[17] == dimLevel[1]) else $error("dim not driven");
  sink_sel_a: assert property (pinRole_q[20] == ROLE_GPIO ##1
    pinRole_q[20] == ROLE_GPIO |-> sinkMode_q[9:8] ==
    $past(gpioSink_q[4].mode)) else $error("wrong sink mode");
  ext_reset_a: assert property (pinRole_q[16] == ROLE_RESET |->
    !padOe[16] ##1 extResetReq_q == $past(padIn[16]))
    else $error("reset pin misbehaves");
  pull_sel_a: assert property (pinRole_q[1] == ROLE_GPIO &&
    dir_q[1] && pinPull_q[1] == NGP_PULL_WEAK |->
    pullWeak[1] && !pullStrong[1]) else $error("wrong pull");
  cdc_sel_a: assert property (cdcOpt_q[0] &&
    pinRole_q[17] == ROLE_DIM |=> constDrive_q[0])
    else $error("constant drive missing");
  opt_frozen_a: assert property (loadState_q == LD_DONE |=>
    $stable(pinRole_q[16]) && $stable(pinPull_q[0]))
    else $error("option changed after load");

  wake_seen_c: cover property (halted ##1 wakeReq_q);
  pad_read_c: cover property (rdEn && dir_q[0] ##1 rdValid_q);
  dim_role_c: cover property (pinRole_q[20] == ROLE_DIM && padOe[20]);
  ext_reset_c: cover property (extResetReq_q);

endmodule

// ### test/ngp_board_model.sv
// board circuitry at the pads: external drivers, pull-lows, floating lines
`timescale 1ns/1ps
module ngp_board_model
  import ngp_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // device pad side
  input wire logic [NGP_MAX_PINS-1:0] padOut,
  input wire logic [NGP_MAX_PINS-1:0] padOe,
  input wire logic [NGP_MAX_PINS-1:0] pullWeak,
  input wire logic [NGP_MAX_PINS-1:0] pullStrong,
  // external drivers
  input wire logic [NGP_MAX_PINS-1:0] extEn,
  input wire logic [NGP_MAX_PINS-1:0] extVal,
  // resolved level
  output logic [NGP_MAX_PINS-1:0] padLvl
);
  logic [NGP_MAX_PINS-1:0] floatQ = '0;
  logic [NGP_MAX_PINS-1:0] pulled;

  // an unheld line wanders, so nobody may rely on its last value
  always_ff @(posedge ref_clk) begin
    floatQ <= ~padLvl;
  end

  // device drive wins, then an external driver; a pull-low (weak or strong) holds an undriven line at 0
  assign pulled = pullWeak | pullStrong;
  assign padLvl = (padOe & padOut) | (~padOe & extEn & extVal) |
    (~padOe & ~extEn & ~pulled & floatQ);
endmodule

// ### test/test_nibble_gpio_ports_with_pin_sharing.sv
// self-checking bench for the nibble gpio ports
`timescale 1ns/1ps
module test_nibble_gpio_ports_with_pin_sharing;
  import ngp_pkg::*;
  logic ref_clk = 1'h0;
  logic resetn = 1'h0;
  logic [2:0] accPort = 3'h0;
  logic dirWrEn = 1'h0, dataWrEn = 1'h0, rdEn = 1'h0, rdDirSel = 1'h0;
  logic [3:0] wrData = 4'h0, rdData_q, v;
  logic rdValid_q, halted = 1'h0, wakeReq_q, extResetReq_q;
  logic [23:0] padIn, padOut, padOe, pullWeak, pullStrong;
  logic [23:0] extEn = 24'hffffff, extVal = 24'h0;
  logic [7:0] dimLevel = 8'h0;
  logic [15:0] keySense_q, sinkMode_q, sinkLevel_q;
  logic [1:0] constDrive_q;
  // straps that the mid-run reset changes
  logic [15:0] optKeyEn = 16'h0001;
  logic [7:0] optDimEn = 8'h81;
  logic optResetEn = 1'h1;
  logic [1:0] optConstDrive = 2'h1;
  int mismatches = 0;
  int cmpCount = 0;
  int n;

  always #2.5 ref_clk = ~ref_clk;

  ngp_top dut (.ref_clk(ref_clk), .resetn(resetn), .accPort(accPort),
    .dirWrEn(dirWrEn), .dataWrEn(dataWrEn), .wrData(wrData), .rdEn(rdEn),
    .rdDirSel(rdDirSel), .rdData_q(rdData_q), .rdValid_q(rdValid_q),
    .halted(halted), .wakeReq_q(wakeReq_q), .padIn(padIn),
    .padOut(padOut), .padOe(padOe), .pullWeak(pullWeak),
    .pullStrong(pullStrong), .optKeyEn(optKeyEn), .optDimEn(optDimEn),
    .optResetEn(optResetEn), .optResetPull(NGP_PULL_WEAK),
    .optPull(48'h000000000024), .optOpenDrain(24'h100000),
    .optGpioSink(32'hb00000a0), .optDimSink(32'ha0000000),
    .optConstDrive(optConstDrive), .dimLevel(dimLevel),
    .keySense_q(keySense_q),
    .extResetReq_q(extResetReq_q), .sinkMode_q(sinkMode_q),
    .sinkLevel_q(sinkLevel_q), .constDrive_q(constDrive_q));

  ngp_board_model board (.ref_clk(ref_clk), .padOut(padOut),
    .padOe(padOe), .pullWeak(pullWeak), .pullStrong(pullStrong),
    .extEn(extEn), .extVal(extVal), .padLvl(padIn));

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    if (mismatches == 0 && cmpCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    cmpCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic isDir, input logic [2:0] p,
                    input logic [3:0] d);
    @(negedge ref_clk);
    accPort = p;
    wrData = d;
    dirWrEn = isDir;
    dataWrEn = ~isDir;
    @(negedge ref_clk);
    dirWrEn = 1'h0;
    dataWrEn = 1'h0;
  endtask

  // rdValid_q stands for one cycle only, so the answer is taken at the next low phase
  task automatic rd(input logic isDir, input logic [2:0] p,
                    output logic [3:0] d);
    @(negedge ref_clk);
    accPort = p;
    rdDirSel = isDir;
    rdEn = 1'h1;
    @(negedge ref_clk);
    rdEn = 1'h0;
    chk("rdValid", {15'h0, rdValid_q}, 16'h1);
    d = rdData_q;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(negedge ref_clk);
    resetn = 1'h1;
    repeat (6) @(negedge ref_clk);
    rd(1'h1, 3'h2, v);
    chk("dirResetC", v, 4'hf);
    chk("oeReset", padOe[15:0], 16'h0);
    extVal[7:4] = 4'ha;
    rd(1'h0, 3'h1, v);
    chk("inputB", v, 4'ha);
    wr(1'h1, 3'h1, 4'h0);
    wr(1'h0, 3'h1, 4'h5);
    extVal[7:4] = 4'h0;
    rd(1'h0, 3'h1, v);
    chk("outputB", v, 4'h5);
    chk("padOutB", padOut[7:4], 4'h5);
    chk("padOeB", padOe[7:4], 4'hf);
    chk("padLvlB", padIn[7:4], 4'h5);
    wr(1'h1, 3'h1, 4'hc);
    extVal[7:4] = 4'h8;
    rd(1'h0, 3'h1, v);
    chk("mixedB", v, 4'h9);
    for (int p = 2; p < 4; p++) begin
      wr(1'h1, 3'(p), 4'h0);
      wr(1'h0, 3'(p), 4'(p + 9));
      rd(1'h0, 3'(p), v);
      chk("portLoop", v, 16'(p + 9));
      wr(1'h1, 3'(p), 4'hf);
    end
    wr(1'h0, 3'h6, 4'hf);
    rd(1'h0, 3'h6, v);
    chk("absentPort", v, 4'h0);
    // key pin keeps its direction whatever is written
    wr(1'h1, 3'h0, 4'h0);
    wr(1'h0, 3'h0, 4'hf);
    chk("keyOe", padOe[3:0], 4'he);
    extVal[0] = 1'h1;
    repeat (2) @(negedge ref_clk);
    chk("keySense", keySense_q, 16'h1);
    wr(1'h1, 3'h0, 4'hf);
    chk("pullWeakA", pullWeak[3:1], 3'h1);
    chk("pullStrongA", pullStrong[3:1], 3'h2);
    // released lines with a pull-low must read low, not wander
    extVal[2:1] = 2'h3;
    extEn[2:1] = 2'h0;
    rd(1'h0, 3'h0, v);
    chk("pulledA", v[2:1], 2'h0);
    extEn[2:1] = 2'h3;
    extVal[2:1] = 2'h0;
    // pin16 is also dim-enabled: reset role must win
    wr(1'h1, 3'h4, 4'h0);
    chk("resetPinOe", padOe[16], 1'h0);
    chk("resetPinPull", pullWeak[16], 1'h1);
    extVal[16] = 1'h1;
    repeat (2) @(negedge ref_clk);
    chk("extReset", extResetReq_q, 1'h1);
    extVal[16] = 1'h0;
    wr(1'h1, 3'h4, 4'hf);
    chk("dimOe", padOe[23], 1'h1);
    dimLevel[7] = 1'h1;
    #1;
    chk("dimHigh", padOut[23], 1'h1);
    dimLevel[7] = 1'h0;
    #1;
    chk("dimLow", padOut[23], 1'h0);
    chk("dimMode", sinkMode_q[15:14], NGP_SINK_CONST);
    chk("dimLevel", sinkLevel_q[15:14], NGP_LVL_83);
    chk("gpioMode", sinkMode_q[3:2], NGP_SINK_CONST);
    chk("gpioLevel", sinkLevel_q[3:2], NGP_LVL_83);
    chk("constDrive", constDrive_q, 2'h1);
    wr(1'h1, 3'h5, 4'h0);
    wr(1'h0, 3'h5, 4'h1);
    chk("odHigh", padOe[20], 1'h0);
    wr(1'h0, 3'h5, 4'h0);
    chk("odLow", {padOe[20], padOut[20]}, 2'h2);
    wr(1'h1, 3'h5, 4'hf);
    // copy pad levels into data before halting, else a false wake-up
    extVal = 24'h0;
    for (int p = 0; p < 6; p++) begin
      rd(1'h0, 3'(p), v);
      wr(1'h0, 3'(p), v);
    end
    halted = 1'h1;
    repeat (3) @(negedge ref_clk);
    chk("wakeQuiet", wakeReq_q, 1'h0);
    extVal[9] = 1'h1;
    n = 0;
    while (wakeReq_q !== 1'h1 && n < 4) begin
      @(negedge ref_clk);
      n++;
    end
    chk("wakeRaised", wakeReq_q, 1'h1);
    if (wakeReq_q !== 1'h1) begin
      test_done();
    end
    halted = 1'h0;
    repeat (2) @(negedge ref_clk);
    chk("wakeCleared", wakeReq_q, 1'h0);
    // second strap set: reset pin off, dim on E0 E1 F0, key on A3
    resetn = 1'h0;
    extVal = 24'h0;
    optKeyEn = 16'h0008;
    optDimEn = 8'h13;
    optResetEn = 1'h0;
    optConstDrive = 2'h3;
    repeat (3) @(negedge ref_clk);
    chk("oeInReset", padOe[23:8], 16'h0);
    resetn = 1'h1;
    repeat (2) @(negedge ref_clk);
    // straps not yet taken two edges after release
    chk("oeEarly", padOe[23:16], 8'h0);
    chk("validEarly", rdValid_q, 1'h0);
    repeat (4) @(negedge ref_clk);
    chk("dimOeB", padOe[23:16], 8'h13);
    chk("constDriveB", constDrive_q, 2'h3);
    chk("dimModeB", sinkMode_q[3:0], 4'h0);
    chk("gpioModeF3", sinkMode_q[15:14], NGP_SINK_CONST);
    chk("gpioLevelF3", sinkLevel_q[15:14], NGP_LVL_100);
    dimLevel[1:0] = 2'h1;
    repeat (2) @(negedge ref_clk);
    chk("dimE0", padOut[17:16], 2'h1);
    chk("noExtReset", extResetReq_q, 1'h0);
    dimLevel[1:0] = 2'h0;
    wr(1'h1, 3'h0, 4'h0);
    chk("keyOeB", padOe[3:0], 4'h7);
    wr(1'h0, 3'h0, 4'h5);
    rd(1'h0, 3'h0, v);
    chk("outputA", v, 4'h5);
    extVal[3] = 1'h1;
    repeat (2) @(negedge ref_clk);
    chk("keySenseB", keySense_q, 16'h8);
    wr(1'h1, 3'h0, 4'hf);
    rd(1'h0, 3'h0, v);
    wr(1'h0, 3'h0, v);
    halted = 1'h1;
    repeat (2) @(negedge ref_clk);
    chk("wakeQuietB", wakeReq_q, 1'h0);
    extVal[0] = 1'h1;
    repeat (2) @(negedge ref_clk);
    chk("wakeA0", wakeReq_q, 1'h1);
    halted = 1'h0;
    test_done();
  end
endmodule
